//--- core/rncr_regs.sv
// Nibble, calibration and debug-read register bank of the interface unit
// Assumes fabric logic on sys_clk drives the register port; the delay
// ready flag arrives from another timing domain and is synchronised here
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "rncr_params.svh"

module rncr_regs
	import rncr_pkg::*;
#(
	parameter logic SERIAL_MODE_ATTR = 1'b0  // Programmed serial setting
) (
	// Clock and reset
	input  wire logic          sys_clk,
	input  wire logic          rstn,
	// Register port
	input  wire rncr_bus_req_t bus_req,
	output logic      [15:0]   reg_rdata,
	// Status sources and delay ready
	input  wire logic [15:0]   self_cal_status,
	input  wire logic [15:0]   other_status,
	input  wire logic          delay_line_ready,
	// Nibble and calibration controls
	output rncr_nib0_t         nib0_ctrl,
	output rncr_nib1_t         nib1_ctrl,
	output rncr_cal_t          cal_ctrl,
	// Debug controls and result
	output logic      [7:0]    debug_read_selector,
	output logic               debug_counter_go,
	output logic      [15:0]   debug_read_result
);

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	logic       wr_nib0;   // Write first nibble control
	logic       wr_nib1;   // Write second nibble control
	logic       wr_cal;    // Write calibration control
	logic       wr_sel;    // Write debug selector
	logic       wr_ctr;    // Write counter control
	logic       in_hole;   // Address in undecoded window

	// Writes only reach decoded registers; all else is dropped
	assign wr_nib0 = bus_req.wr && (bus_req.addr == `RNCR_OFS_NIB0);
	assign wr_nib1 = bus_req.wr && (bus_req.addr == `RNCR_OFS_NIB1);
	assign wr_cal  = bus_req.wr && (bus_req.addr == `RNCR_OFS_CAL);
	assign wr_sel  = bus_req.wr && (bus_req.addr == `RNCR_OFS_DBG_SEL);
	assign wr_ctr  = bus_req.wr && (bus_req.addr == `RNCR_OFS_DBG_CTR);
	assign in_hole = (bus_req.addr >= `RNCR_OFS_HOLE_LO) &&
	                 (bus_req.addr <= `RNCR_OFS_HOLE_HI);

	// ------------------------------------------------------------------
	// Delay ready synchroniser and rise detect
	// ------------------------------------------------------------------
	logic dly_meta_reg;   // First stage, read only by second
	logic dly_sync_reg;   // Second stage
	logic dly_prev_reg;   // Previous synchronised level
	logic dly_meta_next;
	logic dly_sync_next;
	logic dly_prev_next;
	logic ready_rise;     // One-cycle rise of delay ready

	// Next values of the synchroniser chain
	always_comb begin
		dly_meta_next = delay_line_ready;
		dly_sync_next = dly_meta_reg;
		dly_prev_next = dly_sync_reg;
	end

	// Chain registers; reset low so a high level at release counts
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			dly_meta_reg <= 1'b0;
			dly_sync_reg <= 1'b0;
			dly_prev_reg <= 1'b0;
		end else begin
			dly_meta_reg <= dly_meta_next;
			dly_sync_reg <= dly_sync_next;
			dly_prev_reg <= dly_prev_next;
		end
	end

	assign ready_rise = dly_sync_reg && !dly_prev_reg;

	// ------------------------------------------------------------------
	// Write data mapped onto fields
	// ------------------------------------------------------------------
	rncr_nib0_t nib0_wval;   // Field view of a first-nibble write
	rncr_nib1_t nib1_wval;   // Field view of a second-nibble write
	rncr_cal_t  cal_wval;    // Field view of a calibration write
	logic [6:0] serial_mask; // Bit overwritten on delay ready

	// Pick each field from its bit; bits above are reserved
	always_comb begin
		nib0_wval = '0;
		nib0_wval.pos_strobe_source_bit =
			bus_req.wdata[`RNCR_N0_POS_SRC];
		nib0_wval.neg_strobe_source_bit =
			bus_req.wdata[`RNCR_N0_NEG_SRC];
		nib0_wval.receive_clock_invert =
			bus_req.wdata[`RNCR_N0_RX_INV];
		nib0_wval.serial_sample_mode =
			bus_req.wdata[`RNCR_N0_SERIAL];
		nib0_wval.write_clock_gate_off =
			bus_req.wdata[`RNCR_N0_TX_NOGATE];
		nib0_wval.read_clock_gate_off =
			bus_req.wdata[`RNCR_N0_RX_NOGATE];
		nib0_wval.read_gate_lengthen =
			bus_req.wdata[`RNCR_N0_GATE_LEN];
	end

	// Second nibble: clock phase and per-transmitter phase
	always_comb begin
		nib1_wval = '0;
		nib1_wval.pos_rx_phase =
			bus_req.wdata[`RNCR_N1_POS_PH];
		nib1_wval.neg_rx_phase =
			bus_req.wdata[`RNCR_N1_NEG_PH];
		nib1_wval.tx_phase_delay =
			bus_req.wdata[`RNCR_N1_TX_HI:`RNCR_N1_TX_LO];
	end

	// Calibration: one enable, two tracking disables
	always_comb begin
		cal_wval = '0;
		cal_wval.builtin_self_cal =
			bus_req.wdata[`RNCR_CAL_SELF];
		cal_wval.input_drift_follow_off =
			bus_req.wdata[`RNCR_CAL_IN_OFF];
		cal_wval.output_drift_follow_off =
			bus_req.wdata[`RNCR_CAL_OUT_OFF];
	end

	assign serial_mask = 7'(1) << `RNCR_N0_SERIAL;

	// ------------------------------------------------------------------
	// Stored registers
	// ------------------------------------------------------------------
	// Delay ready wins over a same-cycle write, so logic that wants
	// serial sampling must write again after ready is seen
	rncr_field_reg #(.W(7), .RST(`RNCR_RST_NIB0)) u_nib0 (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.sw_we   (wr_nib0),
		.sw_data (nib0_wval),
		.hw_we   (ready_rise),
		.hw_mask (serial_mask),
		.hw_data ({7{SERIAL_MODE_ATTR}} & serial_mask),
		.q       (nib0_ctrl)
	);

	// Second nibble control, software only
	rncr_field_reg #(.W(12), .RST(`RNCR_RST_NIB1)) u_nib1 (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.sw_we   (wr_nib1),
		.sw_data (nib1_wval),
		.hw_we   (1'b0),
		.hw_mask (12'h000),
		.hw_data (12'h000),
		.q       (nib1_ctrl)
	);

	// Calibration control; self-calibration on out of reset
	rncr_field_reg #(.W(3), .RST(`RNCR_RST_CAL)) u_cal (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.sw_we   (wr_cal),
		.sw_data (cal_wval),
		.hw_we   (1'b0),
		.hw_mask (3'h0),
		.hw_data (3'h0),
		.q       (cal_ctrl)
	);

	// Debug read selector, low byte only here
	rncr_field_reg #(.W(8), .RST(`RNCR_RST_SEL)) u_sel (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.sw_we   (wr_sel),
		.sw_data (bus_req.wdata[7:0]),
		.hw_we   (1'b0),
		.hw_mask (8'h00),
		.hw_data (8'h00),
		.q       (debug_read_selector)
	);

	// Debug counter start, one bit
	rncr_field_reg #(.W(1), .RST(`RNCR_RST_CTR)) u_ctr (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.sw_we   (wr_ctr),
		.sw_data (bus_req.wdata[`RNCR_CTR_GO]),
		.hw_we   (1'b0),
		.hw_mask (1'b0),
		.hw_data (1'b0),
		.q       (debug_counter_go)
	);

	// ------------------------------------------------------------------
	// Debug read result
	// ------------------------------------------------------------------
	logic [15:0] res_reg;   // Chosen status, one cycle behind
	logic [15:0] res_next;

	// Registering the mux costs a cycle but keeps the output a flop
	always_comb begin
		if (debug_read_selector[`RNCR_SEL_UPPER]) begin
			res_next = other_status;
		end else begin
			res_next = self_cal_status;
		end
	end

	// Result register, no software write path
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			res_reg <= `RNCR_RST_RES;
		end else begin
			res_reg <= res_next;
		end
	end

	assign debug_read_result = res_reg;

	// ------------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------------
	logic [15:0] rdata_reg;   // Answer, valid only after a read
	logic [15:0] rdata_next;

	// Zero-extend fields; zero outside a read and off the map
	always_comb begin
		rdata_next = 16'h0000;
		if (bus_req.rd) begin
			case (bus_req.addr)
				`RNCR_OFS_NIB0:    rdata_next = {9'h000, nib0_ctrl};
				`RNCR_OFS_NIB1:    rdata_next = {4'h0, nib1_ctrl};
				`RNCR_OFS_CAL:     rdata_next = {13'h0000, cal_ctrl};
				`RNCR_OFS_DBG_SEL: rdata_next = {8'h00, debug_read_selector};
				`RNCR_OFS_DBG_RES: rdata_next = res_reg;
				`RNCR_OFS_DBG_CTR: begin
					rdata_next = {15'h0000, debug_counter_go};
				end
				default:           rdata_next = 16'h0000;
			endcase
		end
	end

	// Read data register
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			rdata_reg <= 16'h0000;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	sequence s_ready_rise;
		!dly_prev_reg && dly_sync_reg;
	endsequence

	sequence s_serial_write;
		wr_nib0 && !ready_rise;
	endsequence

	property p_result_read;
		bus_req.rd && bus_req.addr == `RNCR_OFS_DBG_RES
			|=> reg_rdata == $past(res_reg);
	endproperty
	a_result_read: assert property (p_result_read)
		else $error("debug result read mismatch");

	property p_result_source;
		debug_read_selector[`RNCR_SEL_UPPER]
			|=> debug_read_result == $past(other_status);
	endproperty
	a_result_source: assert property (p_result_source)
		else $error("upper selector did not pick other status");

	property p_result_builtin_self_cal;
		!debug_read_selector[`RNCR_SEL_UPPER]
			|=> debug_read_result == $past(self_cal_status);
	endproperty
	a_result_builtin_self_cal: assert property (p_result_builtin_self_cal)
		else $error("lower selector did not pick self-cal status");

	property p_counter_write;
		wr_ctr |=> debug_counter_go == $past(bus_req.wdata[0])
			##1 debug_counter_go == $past(bus_req.wdata[0], 2)
			    || $past(wr_ctr);
	endproperty
	a_counter_write: assert property (p_counter_write)
		else $error("counter go not stored");

	property p_hole_read;
		bus_req.rd && in_hole |=> reg_rdata == 16'h0000;
	endproperty
	a_hole_read: assert property (p_hole_read)
		else $error("undecoded address returned data");

	property p_hole_write;
		bus_req.wr && in_hole && !ready_rise
			|=> $stable(nib0_ctrl) && $stable(nib1_ctrl)
			    && $stable(cal_ctrl) && $stable(debug_counter_go);
	endproperty
	a_hole_write: assert property (p_hole_write)
		else $error("undecoded write changed a register");

	property p_nib0_write;
		s_serial_write |=> nib0_ctrl == $past(bus_req.wdata[6:0]);
	endproperty
	a_nib0_write: assert property (p_nib0_write)
		else $error("first nibble write not stored");

	property p_serial_revert;
		s_ready_rise |=> nib0_ctrl.serial_sample_mode == SERIAL_MODE_ATTR;
	endproperty
	a_serial_revert: assert property (p_serial_revert)
		else $error("serial mode not restored on delay ready");

	property p_nib1_write;
		wr_nib1 |=> nib1_ctrl == $past(bus_req.wdata[11:0]);
	endproperty
	a_nib1_write: assert property (p_nib1_write)
		else $error("second nibble write not stored");

	property p_cal_write;
		wr_cal |=> cal_ctrl == $past(bus_req.wdata[2:0]);
	endproperty
	a_cal_write: assert property (p_cal_write)
		else $error("calibration write not stored");

	property p_reset_values;
		$rose(rstn) |-> cal_ctrl == `RNCR_RST_CAL
			&& nib0_ctrl == `RNCR_RST_NIB0 && nib1_ctrl == `RNCR_RST_NIB1;
	endproperty
	a_reset_values: assert property (p_reset_values)
		else $error("control reset values wrong");

	// The debug result is a full 16-bit status word, so it is left out
	property p_reserved_zero;
		bus_req.rd && bus_req.addr != `RNCR_OFS_DBG_RES
			|=> reg_rdata[15:12] == 4'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved bits read nonzero");

	property p_idle_rdata;
		!bus_req.rd |=> reg_rdata == 16'h0000;
	endproperty
	a_idle_rdata: assert property (p_idle_rdata)
		else $error("read data outside read cycle");

endmodule

`default_nettype wire

//--- core/rncr_params.svh
// Offsets, reset values and field positions of the nibble/calibration bank
// Assumes inclusion by bare name from the top module, the fabric model and the bench
`ifndef RNCR_PARAMS_SVH
`define RNCR_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (word addresses on the register port)
// ----------------------------------------------------------------------
`define RNCR_OFS_NIB0     8'h00
`define RNCR_OFS_NIB1     8'h01
`define RNCR_OFS_CAL      8'h02
`define RNCR_OFS_DBG_SEL  8'h38
`define RNCR_OFS_DBG_RES  8'h39
`define RNCR_OFS_DBG_CTR  8'h3a
`define RNCR_OFS_HOLE_LO  8'h3b
`define RNCR_OFS_HOLE_HI  8'h3f

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RNCR_RST_NIB0     7'h00
`define RNCR_RST_NIB1     12'h000
`define RNCR_RST_CAL      3'h1
`define RNCR_RST_CTR      1'h0
`define RNCR_RST_SEL      8'h00
`define RNCR_RST_RES      16'h0000

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RNCR_N0_POS_SRC   0
`define RNCR_N0_NEG_SRC   1
`define RNCR_N0_RX_INV    2
`define RNCR_N0_SERIAL    3
`define RNCR_N0_TX_NOGATE 4
`define RNCR_N0_RX_NOGATE 5
`define RNCR_N0_GATE_LEN  6
`define RNCR_N1_POS_PH    0
`define RNCR_N1_NEG_PH    1
`define RNCR_N1_TX_LO     2
`define RNCR_N1_TX_HI     11
`define RNCR_CAL_SELF     0
`define RNCR_CAL_IN_OFF   1
`define RNCR_CAL_OUT_OFF  2
`define RNCR_CTR_GO       0
`define RNCR_SEL_UPPER    7

`endif

//--- core/rncr_pkg.sv
// Types shared by the nibble/calibration register bank
// Assumes the params header sits beside it in core/
package rncr_pkg;

	// ------------------------------------------------------------------
	// Register port request
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  addr;   // Word address
		logic [15:0] wdata;  // Write data
		logic        wr;     // Write strobe
		logic        rd;     // Read strobe
	} rncr_bus_req_t;

	// ------------------------------------------------------------------
	// Control carriers, msb first so bit i is field position i
	// ------------------------------------------------------------------
	typedef struct packed {
		logic read_gate_lengthen;     // Bit 6
		logic read_clock_gate_off;    // Bit 5
		logic write_clock_gate_off;   // Bit 4
		logic serial_sample_mode;     // Bit 3
		logic receive_clock_invert;   // Bit 2
		logic neg_strobe_source_bit;  // Bit 1
		logic pos_strobe_source_bit;  // Bit 0
	} rncr_nib0_t;

	typedef struct packed {
		logic [9:0] tx_phase_delay;   // Bits 11:2, one per transmitter
		logic       neg_rx_phase;     // Bit 1
		logic       pos_rx_phase;     // Bit 0
	} rncr_nib1_t;

	typedef struct packed {
		logic output_drift_follow_off; // Bit 2
		logic input_drift_follow_off;  // Bit 1
		logic builtin_self_cal;        // Bit 0
	} rncr_cal_t;

endpackage

//--- core/rncr_field_reg.sv
// One software register with an optional hardware overwrite per bit
// Assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module rncr_field_reg #(
	parameter int             W   = 8,
	parameter logic [W-1:0]   RST = '0
) (
	// Clock and reset
	input  wire logic         sys_clk,
	input  wire logic         rstn,
	// Software side
	input  wire logic         sw_we,
	input  wire logic [W-1:0] sw_data,
	// Hardware overwrite, wins over software
	input  wire logic         hw_we,
	input  wire logic [W-1:0] hw_mask,
	input  wire logic [W-1:0] hw_data,
	// Stored value
	output logic      [W-1:0] q
);

	logic [W-1:0] q_reg;   // Stored bits
	logic [W-1:0] q_next;  // Next value

	// ------------------------------------------------------------------
	// Next value: software first, hardware overwrite on top
	// ------------------------------------------------------------------
	always_comb begin
		q_next = q_reg;
		if (sw_we) begin
			q_next = sw_data;
		end
		if (hw_we) begin
			// Masked bits only; others keep the software result
			q_next = (q_next & ~hw_mask) | (hw_data & hw_mask);
		end
	end

	// Register only
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			q_reg <= RST;
		end else begin
			q_reg <= q_next;
		end
	end

	assign q = q_reg;

endmodule

`default_nettype wire

//--- verification/rncr_fabric_model.sv
// Fabric-side master model of the register port of the bank
// Assumes one clock; requests change just after a rising edge
`timescale 1ns/1ps
`default_nettype none
`include "rncr_params.svh"

module rncr_fabric_model
	import rncr_pkg::*;
(
	// Clock
	input  wire logic        sys_clk,
	// Delay ready, watched before a serial rewrite
	input  wire logic        delay_line_ready,
	// Register port
	output rncr_bus_req_t    bus_req,
	input  wire logic [15:0] reg_rdata
);
	// ------------------------------------------------------------------
	// Bus cycles
	// ------------------------------------------------------------------
	// Idle port from time zero
	initial begin
		bus_req = '0;
	end

	// One-cycle write, held up to the taking edge
	task automatic do_write(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus_req <= '0;
	endtask

	// One-cycle read; answer stands only in the following cycle
	task automatic do_read(input logic [7:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus_req <= '0;
		@(posedge sys_clk);
		d = reg_rdata;
	endtask

	// Serial bit is lost on ready, so software must set it again
	task automatic rewrite_after_ready(input logic [15:0] d,
		output logic ok);
		ok = 1'b0;
		for (int i = 0; i < 16 && !ok; i++) begin
			@(posedge sys_clk);
			ok = (delay_line_ready === 1'b1);
		end
		// Let the synchronised restore land first, it wins a tie
		repeat (4) @(posedge sys_clk);
		if (ok) begin
			do_write(`RNCR_OFS_NIB0, d);
		end
	endtask
endmodule
`default_nettype wire

//--- verification/riu_nibble_calib_regs_test.sv
// Self-checking bench of the nibble/calibration register bank
// Assumes the fabric model in its own file and the params header
`timescale 1ns/1ps
`default_nettype none
`include "rncr_params.svh"

module riu_nibble_calib_regs_test
	import rncr_pkg::*;
;
	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	logic          sys_clk;          // 40 MHz clock
	logic          rstn;             // Synchronous reset, low
	rncr_bus_req_t bus_req;          // Port request from model
	logic [15:0]   reg_rdata;        // Read answer
	logic [15:0]   self_cal_status;  // Lower-half source
	logic [15:0]   other_status;     // Upper-half source
	logic          delay_line_ready; // Ready flag, async to bank
	rncr_nib0_t    nib0_ctrl;        // First nibble controls
	rncr_nib1_t    nib1_ctrl;        // Second nibble controls
	rncr_cal_t     cal_ctrl;         // Calibration controls
	logic [7:0]    sel;              // Selector output
	logic          go;               // Counter start output
	logic [15:0]   res;              // Debug result output
	logic          ok;               // Model wait outcome
	int            miscompares;      // Failed comparisons
	int            samples_checked;  // All comparisons

	// Clock, 25 ns period
	initial sys_clk = 1'b0;
	always #12.5 sys_clk = ~sys_clk;

	// ------------------------------------------------------------------
	// Instances
	// ------------------------------------------------------------------
	rncr_regs #(.SERIAL_MODE_ATTR(1'b0)) DUT (
		.sys_clk(sys_clk), .rstn(rstn), .bus_req(bus_req),
		.reg_rdata(reg_rdata), .self_cal_status(self_cal_status),
		.other_status(other_status), .delay_line_ready(delay_line_ready),
		.nib0_ctrl(nib0_ctrl), .nib1_ctrl(nib1_ctrl), .cal_ctrl(cal_ctrl),
		.debug_read_selector(sel), .debug_counter_go(go),
		.debug_read_result(res));
	rncr_fabric_model FAB (
		.sys_clk(sys_clk), .delay_line_ready(delay_line_ready),
		.bus_req(bus_req), .reg_rdata(reg_rdata));

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// Compare and count; an unknown bit matches only an unknown
	task automatic check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Verdict and end of run
	task automatic finish_test();
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Read through the model and compare
	task automatic rd_chk(input string name, input logic [7:0] a,
		input logic [15:0] exp);
		logic [15:0] d;
		FAB.do_read(a, d);
		check(name, d, exp);
	endtask

	// Output view of a register, zero-extended to a word
	function automatic logic [15:0] out_of(input logic [7:0] a);
		case (a)
			`RNCR_OFS_NIB0:    return {9'h000, nib0_ctrl};
			`RNCR_OFS_NIB1:    return {4'h0, nib1_ctrl};
			`RNCR_OFS_CAL:     return {13'h0000, cal_ctrl};
			`RNCR_OFS_DBG_CTR: return {15'h0000, go};
			`RNCR_OFS_DBG_SEL: return {8'h00, sel};
			default:           return res;
		endcase
	endfunction

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	// Every field at its reset value, on outputs and by read
	task automatic t_reset();
		logic [7:0]  a [6];
		logic [15:0] v [6];
		a = '{`RNCR_OFS_NIB0, `RNCR_OFS_NIB1, `RNCR_OFS_CAL,
			`RNCR_OFS_DBG_CTR, `RNCR_OFS_DBG_SEL, `RNCR_OFS_DBG_RES};
		v = '{16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000};
		for (int i = 0; i < 6; i++) begin
			check("reset out", out_of(a[i]), v[i]);
			rd_chk("reset rd", a[i], v[i]);
		end
	endtask

	// Walking one, then all ones against the implemented mask
	task automatic walk(input string name, input logic [7:0] a,
		input int n, input logic [15:0] rst);
		logic [15:0] m;
		m = 16'hffff >> (16 - n);
		for (int i = 0; i < n; i++) begin
			FAB.do_write(a, 16'h0001 << i);
			@(negedge sys_clk);
			check(name, out_of(a), 16'h0001 << i);
			rd_chk(name, a, 16'h0001 << i);
		end
		FAB.do_write(a, 16'hffff);
		@(negedge sys_clk);
		check(name, out_of(a), m);
		rd_chk(name, a, m);
		FAB.do_write(a, rst);
	endtask

	// Source choice at both sides of the half boundary
	task automatic t_debug();
		self_cal_status <= 16'h1234;
		other_status    <= 16'habcd;
		FAB.do_write(`RNCR_OFS_DBG_SEL, 16'h007f);
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		check("res lo", res, 16'h1234);
		rd_chk("res lo rd", `RNCR_OFS_DBG_RES, 16'h1234);
		FAB.do_write(`RNCR_OFS_DBG_SEL, 16'hff80);
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		check("res hi", res, 16'habcd);
		// Read-only place must not take the write
		FAB.do_write(`RNCR_OFS_DBG_RES, 16'h5555);
		rd_chk("res ro", `RNCR_OFS_DBG_RES, 16'habcd);
		rd_chk("sel rd", `RNCR_OFS_DBG_SEL, 16'h0080);
		FAB.do_write(`RNCR_OFS_DBG_SEL, 16'h0000);
	endtask

	// Hole above counter control, and the unmapped word just past it
	task automatic t_hole();
		for (int a = 8'h3b; a <= 8'h40; a++) begin
			FAB.do_write(a[7:0], 16'hffff);
			rd_chk("hole", a[7:0], 16'h0000);
		end
		check("hole nib0", out_of(`RNCR_OFS_NIB0), 16'h0000);
		check("hole nib1", out_of(`RNCR_OFS_NIB1), 16'h0000);
		check("hole cal", out_of(`RNCR_OFS_CAL), 16'h0001);
		check("hole go", out_of(`RNCR_OFS_DBG_CTR), 16'h0000);
	endtask

	// Serial bit falls back on ready, others stay, rewrite holds
	task automatic t_serial();
		FAB.do_write(`RNCR_OFS_NIB0, 16'h0019);
		@(posedge sys_clk);
		delay_line_ready <= 1'b1;
		for (int i = 0; i < 8 && nib0_ctrl.serial_sample_mode !== 1'b0;
			i++) begin
			@(negedge sys_clk);
		end
		check("serial restore", out_of(`RNCR_OFS_NIB0), 16'h0011);
		if (nib0_ctrl.serial_sample_mode !== 1'b0) begin
			finish_test();
		end
		FAB.rewrite_after_ready(16'h0019, ok);
		check("ready seen", {15'h0000, ok}, 16'h0001);
		if (ok !== 1'b1) begin
			finish_test();
		end
		repeat (4) @(negedge sys_clk);
		check("serial kept", out_of(`RNCR_OFS_NIB0), 16'h0019);
		rd_chk("serial rd", `RNCR_OFS_NIB0, 16'h0019);
		delay_line_ready <= 1'b0;
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		rstn             = 1'b0;
		self_cal_status  = 16'h0000;
		other_status     = 16'h0000;
		delay_line_ready = 1'b0;
		miscompares      = 0;
		samples_checked  = 0;
		repeat (4) @(posedge sys_clk);
		rstn <= 1'b1;
		@(negedge sys_clk);
		t_reset();
		walk("nib0", `RNCR_OFS_NIB0, 7, 16'h0000);
		walk("nib1", `RNCR_OFS_NIB1, 12, 16'h0000);
		walk("cal", `RNCR_OFS_CAL, 3, 16'h0001);
		walk("ctr", `RNCR_OFS_DBG_CTR, 1, 16'h0000);
		walk("sel", `RNCR_OFS_DBG_SEL, 8, 16'h0000);
		t_debug();
		t_hole();
		t_serial();
		finish_test();
	end
endmodule
`default_nettype wire
